// file: src/rpe_top.sv
// Redundancy path enable register of a three channel line interface.
// Assumes the host port delivers decoded byte accesses on clk; line pins are asynchronous.
//
// Operation
// - Eight-bit control register at 0x00, resets zero.
// - Bit 6 powers channel 2 receive section.
// - Bit 5 powers channel 1 receive section.
// - Bit 4 powers channel 0 receive section.
// - Receive bit low powers whole section down.
// - Receive bit high accepts incoming line data.
// - Bit 2 drives or tri-states channel 2; it drives only while channel 2's enable pin is high.
// - Bits 1, 0 drive channels 1, 0 while those channels' enable pins are high.
`timescale 1ns/1ps
`default_nettype none
module rpe_top
  import rpe_pkg::*;
#(
  parameter int NUM_CH = RPE_NUM_CH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] tx_enable_pin,
  input wire logic [2:0] rx_line_pos,
  input wire logic [2:0] rx_line_neg,
  input wire logic [2:0] tx_data_pos,
  input wire logic [2:0] tx_data_neg,
  output logic [2:0] rx_data_pos,
  output logic [2:0] rx_data_neg,
  output logic [2:0] receive_section_power,
  output logic [2:0] tx_line_pos_o,
  output logic [2:0] tx_line_neg_o,
  output logic [2:0] tx_line_oe_n
);
  if (NUM_CH != 3) begin : g_bad_ch
    $error("The control register holds exactly three channels.");
  end

  logic [7:0] redundancy_control;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] rxp_meta;
  logic [2:0] rxp_sync;
  logic [2:0] rxn_meta;
  logic [2:0] rxn_sync;
  logic ctrl_hit;

  assign ctrl_hit = (reg_addr == RPE_CTRL_OFFSET);

  always_ff @(posedge clk) begin
    if (rst) begin
      redundancy_control <= RPE_CTRL_RESET;
    end else if (reg_wr && ctrl_hit) begin
      redundancy_control <= reg_wdata & RPE_CTRL_WMASK;
    end
  end

  // Reads of other offsets return zero because those registers live elsewhere.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= RPE_UNMAPPED_READ;
    end else if (reg_rd) begin
      reg_rdata <= ctrl_hit ? redundancy_control : RPE_UNMAPPED_READ;
    end
  end

  // Enable and receive line pins are asynchronous to clk, so each passes two flip-flops first; transmit data pins pass none.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      rxp_meta <= 3'h0;
      rxp_sync <= 3'h0;
      rxn_meta <= 3'h0;
      rxn_sync <= 3'h0;
    end else begin
      pin_meta <= tx_enable_pin;
      pin_sync <= pin_meta;
      rxp_meta <= rx_line_pos;
      rxp_sync <= rxp_meta;
      rxn_meta <= rx_line_neg;
      rxn_sync <= rxn_meta;
    end
  end

  assign receive_section_power = redundancy_control[RPE_RX_ON_LSB +: 3];

  rpe_ch_if ch_if[3] ();

  for (genvar i = 0; i < 3; i++) begin : g_ch
    assign ch_if[i].rx_on = redundancy_control[RPE_RX_ON_LSB + i];
    assign ch_if[i].tx_on = redundancy_control[RPE_TX_ON_LSB + i] & pin_sync[i];
    assign ch_if[i].rx_pos = rxp_sync[i];
    assign ch_if[i].rx_neg = rxn_sync[i];
    assign ch_if[i].tx_pos = tx_data_pos[i];
    assign ch_if[i].tx_neg = tx_data_neg[i];
    assign rx_data_pos[i] = ch_if[i].rx_data_pos;
    assign rx_data_neg[i] = ch_if[i].rx_data_neg;
    assign tx_line_pos_o[i] = ch_if[i].tx_out_pos;
    assign tx_line_neg_o[i] = ch_if[i].tx_out_neg;
    assign tx_line_oe_n[i] = ch_if[i].tx_oe_n;
    rpe_channel u_ch (
      .clk(clk),
      .rst(rst),
      .ch(ch_if[i].chan)
    );
  end

  a_reg_reset_zero: assert property (@(posedge clk) rst |=> redundancy_control == 8'h00)
    else $error("Control register not zero after reset.");

  a_rx2_write: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && ctrl_hit) |=> receive_section_power[2] == $past(reg_wdata[6]))
    else $error("Channel 2 receive bit did not take the write.");

  a_rx1_write: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && ctrl_hit) |=> receive_section_power[1] == $past(reg_wdata[5]))
    else $error("Channel 1 receive bit did not take the write.");

  a_rx0_write: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && ctrl_hit) |=> receive_section_power[0] == $past(reg_wdata[4]))
    else $error("Channel 0 receive bit did not take the write.");

  a_tx2_write_drive: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && ctrl_hit && reg_wdata[2] && pin_sync[2]) ##1 pin_sync[2] |=> !tx_line_oe_n[2])
    else $error("Channel 2 driver not enabled after write.");

  a_tx_pin_low_off: assert property (@(posedge clk) disable iff (rst)
    (pin_sync == 3'h0) |=> tx_line_oe_n == 3'h7)
    else $error("Driver on while its enable pin was low.");

  a_reserved_read: assert property (@(posedge clk) disable iff (rst)
    reg_rd |=> (reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0))
    else $error("Reserved bit read as one.");

  a_read_value: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && ctrl_hit) |=> reg_rdata == $past(redundancy_control))
    else $error("Read did not return the register.");

  a_tx1_write_drive: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && ctrl_hit && reg_wdata[1] && pin_sync[1]) ##1 pin_sync[1] |=> !tx_line_oe_n[1])
    else $error("Channel 1 driver not enabled after write.");

  a_tx0_write_drive: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && ctrl_hit && reg_wdata[0] && pin_sync[0]) ##1 pin_sync[0] |=> !tx_line_oe_n[0])
    else $error("Channel 0 driver not enabled after write.");

  a_tx2_clear_off: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && ctrl_hit && !reg_wdata[2]) |=> ##1 tx_line_oe_n[2])
    else $error("Channel 2 driver still on after its bit was cleared.");

  a_tx1_clear_off: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && ctrl_hit && !reg_wdata[1]) |=> ##1 tx_line_oe_n[1])
    else $error("Channel 1 driver still on after its bit was cleared.");

  a_tx0_clear_off: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && ctrl_hit && !reg_wdata[0]) |=> ##1 tx_line_oe_n[0])
    else $error("Channel 0 driver still on after its bit was cleared.");

  a_tx2_off_zero: assert property (@(posedge clk) disable iff (rst)
    tx_line_oe_n[2] |-> (!tx_line_pos_o[2] && !tx_line_neg_o[2]))
    else $error("Channel 2 line data moved while tri-stated.");

  a_tx1_off_zero: assert property (@(posedge clk) disable iff (rst)
    tx_line_oe_n[1] |-> (!tx_line_pos_o[1] && !tx_line_neg_o[1]))
    else $error("Channel 1 line data moved while tri-stated.");

  a_tx0_off_zero: assert property (@(posedge clk) disable iff (rst)
    tx_line_oe_n[0] |-> (!tx_line_pos_o[0] && !tx_line_neg_o[0]))
    else $error("Channel 0 line data moved while tri-stated.");

  a_tx_data_follow: assert property (@(posedge clk) disable iff (rst)
    !tx_line_oe_n[2] |-> (tx_line_pos_o[2] == $past(tx_data_pos[2]) &&
      tx_line_neg_o[2] == $past(tx_data_neg[2])))
    else $error("Channel 2 driver did not pass its data.");

  a_rx2_clear_quiet: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && ctrl_hit && !reg_wdata[6]) |=> ##1 (rx_data_pos[2] == 1'b0 && rx_data_neg[2] == 1'b0))
    else $error("Channel 2 receive data moved after power down.");

  a_rx1_clear_quiet: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && ctrl_hit && !reg_wdata[5]) |=> ##1 (rx_data_pos[1] == 1'b0 && rx_data_neg[1] == 1'b0))
    else $error("Channel 1 receive data moved after power down.");

  a_rx0_clear_quiet: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && ctrl_hit && !reg_wdata[4]) |=> ##1 (rx_data_pos[0] == 1'b0 && rx_data_neg[0] == 1'b0))
    else $error("Channel 0 receive data moved after power down.");

  a_rx_sync_depth: assert property (@(posedge clk) disable iff (rst)
    (!$past(rst) && !$past(rst, 2)) |-> (rxp_sync == $past(rx_line_pos, 2) && rxn_sync == $past(rx_line_neg, 2)))
    else $error("Receive line synchroniser is not two stages deep.");

  a_pin_sync_depth: assert property (@(posedge clk) disable iff (rst)
    (!$past(rst) && !$past(rst, 2)) |-> pin_sync == $past(tx_enable_pin, 2))
    else $error("Transmit enable pin synchroniser is not two stages deep.");

  a_reg_hold: assert property (@(posedge clk) disable iff (rst)
    !(reg_wr && ctrl_hit) |=> $stable(redundancy_control))
    else $error("Control register changed without a write to it.");

  a_rx_power_stable: assert property (@(posedge clk) disable iff (rst)
    !(reg_wr && ctrl_hit) |=> $stable(receive_section_power))
    else $error("Receive power changed without a write.");

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    (redundancy_control[7] == 1'b0 && redundancy_control[3] == 1'b0))
    else $error("Reserved register bit was stored.");

  a_read_hold: assert property (@(posedge clk) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("Read data changed without a read.");

  a_unmapped_read: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && !ctrl_hit) |=> reg_rdata == RPE_UNMAPPED_READ)
    else $error("Read of another offset did not return zero.");
endmodule : rpe_top
`default_nettype wire

// file: inc/rpe_pkg.sv
// Constants for the redundancy path enable register and its channel slices.
// Assumes the host port has already been decoded into byte-wide register accesses.
package rpe_pkg;
  localparam int RPE_NUM_CH = 3;
  localparam logic [7:0] RPE_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] RPE_CTRL_RESET = 8'h00;
  localparam int RPE_RX_ON_LSB = 4;
  localparam int RPE_TX_ON_LSB = 0;
  localparam logic [7:0] RPE_CTRL_WMASK = 8'h77;
  localparam logic [7:0] RPE_UNMAPPED_READ = 8'h00;
endpackage : rpe_pkg

// file: inc/rpe_ch_if.sv
// Signals between the control register and one channel slice.
// Assumes all members are in the clk domain; line inputs arrive already synchronised.
`timescale 1ns/1ps
`default_nettype none
interface rpe_ch_if;
  logic rx_on;
  logic tx_on;
  logic rx_pos;
  logic rx_neg;
  logic tx_pos;
  logic tx_neg;
  logic rx_data_pos;
  logic rx_data_neg;
  logic tx_out_pos;
  logic tx_out_neg;
  logic tx_oe_n;
  modport ctl (output rx_on, tx_on, rx_pos, rx_neg, tx_pos, tx_neg,
               input rx_data_pos, rx_data_neg, tx_out_pos, tx_out_neg, tx_oe_n);
  modport chan (input rx_on, tx_on, rx_pos, rx_neg, tx_pos, tx_neg,
                output rx_data_pos, rx_data_neg, tx_out_pos, tx_out_neg, tx_oe_n);
endinterface : rpe_ch_if
`default_nettype wire

// file: src/rpe_channel.sv
// One channel slice: receive section gating and transmit driver enable.
// Assumes synchronous inputs on clk; line pins are resolved outside from the enables.
`timescale 1ns/1ps
`default_nettype none
module rpe_channel (
  input wire logic clk,
  input wire logic rst,
  rpe_ch_if.chan ch
);
  always_ff @(posedge clk) begin
    if (rst || !ch.rx_on) begin
      ch.rx_data_pos <= 1'b0;
      ch.rx_data_neg <= 1'b0;
    end else begin
      ch.rx_data_pos <= ch.rx_pos;
      ch.rx_data_neg <= ch.rx_neg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ch.tx_out_pos <= 1'b0;
      ch.tx_out_neg <= 1'b0;
      ch.tx_oe_n <= 1'b1;
    end else begin
      ch.tx_out_pos <= ch.tx_on & ch.tx_pos;
      ch.tx_out_neg <= ch.tx_on & ch.tx_neg;
      ch.tx_oe_n <= ~ch.tx_on;
    end
  end

  a_rx_off_quiet: assert property (@(posedge clk) disable iff (rst)
    !ch.rx_on |=> (ch.rx_data_pos == 1'b0 && ch.rx_data_neg == 1'b0))
    else $error("Receive data moved while section was off.");

  a_rx_on_follows: assert property (@(posedge clk) disable iff (rst)
    ch.rx_on |=> (ch.rx_data_pos == $past(ch.rx_pos) && ch.rx_data_neg == $past(ch.rx_neg)))
    else $error("Receive data did not follow the line.");

  a_tx_on_drives: assert property (@(posedge clk) disable iff (rst)
    ch.tx_on |=> (!ch.tx_oe_n && ch.tx_out_pos == $past(ch.tx_pos)))
    else $error("Enabled driver did not drive the line.");

  a_tx_off_tristate: assert property (@(posedge clk) disable iff (rst)
    !ch.tx_on |=> (ch.tx_oe_n && !ch.tx_out_pos && !ch.tx_out_neg))
    else $error("Disabled driver was not tri-stated.");
endmodule : rpe_channel
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the redundancy path enable register and its channel gating.
// Assumes rpe_pkg and rpe_ch_if are compiled first and a 100 MHz clock on rpe_top.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  import rpe_pkg::*;
  logic clk, rst, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, r;
  logic [2:0] tx_enable_pin, rx_line_pos, rx_line_neg, tx_data_pos, tx_data_neg, rx_data_pos, rx_data_neg;
  logic [2:0] receive_section_power, tx_line_pos_o, tx_line_neg_o, tx_line_oe_n, en;
  int err_total, num_checks;
  rpe_top i_rpe_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_enable_pin(tx_enable_pin), .rx_line_pos(rx_line_pos),
    .rx_line_neg(rx_line_neg), .tx_data_pos(tx_data_pos), .tx_data_neg(tx_data_neg),
    .rx_data_pos(rx_data_pos), .rx_data_neg(rx_data_neg), .receive_section_power(receive_section_power),
    .tx_line_pos_o(tx_line_pos_o), .tx_line_neg_o(tx_line_neg_o), .tx_line_oe_n(tx_line_oe_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  // The host port strobes are one-cycle pulses, so each task releases its strobe on the taking edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // Expected transmit enables: register bit and board pin must both be high.
  function automatic logic [2:0] tx_en(input logic [7:0] r, input logic [2:0] pin);
    return r[2:0] & pin;
  endfunction : tx_en
  // Reserved bits never store, so a read returns the write with them cleared.
  function automatic logic [7:0] exp_reg(input logic [7:0] d);
    return d & RPE_CTRL_WMASK;
  endfunction : exp_reg
  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    tx_enable_pin = 3'h0;
    {rx_line_pos, rx_line_neg, tx_data_pos, tx_data_neg} = 12'h000;
    err_total = 0;
    num_checks = 0;
    void'($urandom(56971));
    repeat (5) @(posedge clk);
    #1;
    `CHK(tx_line_oe_n, 3'h7)
    `CHK(receive_section_power, 3'h0)
    rst <= 1'b0;
    rd(RPE_CTRL_OFFSET, v);
    `CHK(v, RPE_CTRL_RESET)
    wr(8'h00, 8'hff);
    rd(8'h00, v);
    `CHK(v, 8'h77)
    // other offsets leave the register alone
    wr(8'h01, 8'h00);
    rd(8'h00, v);
    `CHK(v, 8'h77)
    rd(8'h3e, v);
    `CHK(v, RPE_UNMAPPED_READ)
    for (int i = 0; i < 40; i++) begin
      v = (i < 2) ? {i[0] ? 8'h88 : 8'h00} : $urandom();
      @(posedge clk);
      tx_enable_pin <= (i == 2) ? 3'h0 : $urandom();
      {rx_line_pos, rx_line_neg, tx_data_pos, tx_data_neg} <= $urandom();
      wr(8'h00, v);
      #1;
      // receive power bits follow the write
      `CHK(receive_section_power, v[6:4])
      // Synchroniser depth plus output stage is three edges; four leaves margin.
      repeat (4) @(posedge clk);
      #1;
      en = tx_en(v, tx_enable_pin);
      `CHK(tx_line_oe_n, ~en)
      `CHK(tx_line_pos_o, tx_data_pos & en)
      `CHK(tx_line_neg_o, tx_data_neg & en)
      `CHK(rx_data_pos, rx_line_pos & v[6:4])
      `CHK(rx_data_neg, rx_line_neg & v[6:4])
      rd(8'h00, r);
      `CHK(r, exp_reg(v))
      `CHK(r[7], 1'b0)
      `CHK(r[3], 1'b0)
    end
    // mid-run reset clears a set register
    @(posedge clk);
    tx_enable_pin <= 3'h7;
    wr(RPE_CTRL_OFFSET, 8'h77);
    #1;
    `CHK(receive_section_power, 3'h7)
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK(receive_section_power, 3'h0)
    `CHK(tx_line_oe_n, 3'h7)
    `CHK({rx_data_pos, rx_data_neg}, 6'h00)
    rd(RPE_CTRL_OFFSET, r);
    `CHK(r, RPE_CTRL_RESET)
    stop_test();
  end
  initial begin
    #200000;
    err_total++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
